// *** inc/slpr_regs.svh ***
// register map, field positions, reset values for the link parameter bank
`ifndef SLPR_REGS_SVH
`define SLPR_REGS_SVH
`define SLPR_A_SCR_LANE  13'h006E
`define SLPR_A_F         13'h006F
`define SLPR_A_K         13'h0070
`define SLPR_A_M         13'h0071
`define SLPR_A_NCS       13'h0072
`define SLPR_A_SUBNP     13'h0073
`define SLPR_A_S         13'h0074
`define SLPR_A_HDCF      13'h0075
`define SLPR_A_SCR1      13'h0076
`define SLPR_A_SCR2      13'h0077
`define SLPR_A_CKSUM     13'h0079
`define SLPR_A_DRV       13'h0080
`define SLPR_A_LMFC      13'h008B
`define SLPR_A_EMPH      13'h00A8
`define SLPR_SCR_BIT     7
`define SLPR_LANE_MSB    4
`define SLPR_CS_MSB      7
`define SLPR_CS_LSB      6
`define SLPR_SUB_MSB     6
`define SLPR_SUB_LSB     5
`define SLPR_SRSV_BIT    5
`define SLPR_DRV_PD_BIT  1
`define SLPR_OFF_MSB     4
`define SLPR_N_VAL       4'hD
`define SLPR_NP_VAL      4'hF
`define SLPR_S_VAL       5'h00
`define SLPR_HD_VAL      1'h0
`define SLPR_CF_VAL      5'h00
`define SLPR_EMPH_OFF    8'h04
`define SLPR_EMPH_ON     8'h14
`define SLPR_SUB1_CODE   2'h1
`define SLPR_RST_K       8'h20
`define SLPR_RST_SRSV    1'h1
`define SLPR_INSTR_LAST  4'hF
`define SLPR_DATA_LAST   4'h7
`define SLPR_RW_BIT      15
`define SLPR_ADDR_MSB    12
`endif

// *** inc/slpr_pkg.sv ***
// types shared by the link parameter bank
package slpr_pkg;
	// serial port transfer phases
	typedef enum logic [1:0] {
		ST_INSTR,
		ST_WDATA,
		ST_RDATA,
		ST_DONE
	} slpr_spi_state_t;
endpackage

// *** src/slpr_regs_top.sv ***
// link parameter register bank behind a three-wire serial port
// Notes on behaviour
// - scrambler bit one scrambles, zero disables
// - lane field zero means one lane
// - octets per frame reads twice converters over lanes
// - converter count zero means one converter
// - control bit code selects zero, one, two
// - resolution field reads thirteen
// - subclass code zero or one selects mode
// - bits per sample field reads fifteen
// - samples field reads zero; host sets bit5
// - high density and control words read zero
// - two free scratch registers read back
// - checksum is parameter sum modulo 256
// - driver power down bit gates drivers
// - sysref loads offset into phase counter
// - emphasis value 0x14 enables, 0x04 disables
`include "slpr_regs.svh"
module slpr_regs_top (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       spi_sclk,
	input  wire logic       spi_cs_n,
	input  wire logic       sdio_in,
	output logic            sdio_out,
	output logic            sdio_oe,
	output logic            scramble_en,
	output logic            driver_power_down,
	output logic            preemphasis_en,
	output logic [1:0]      ctrl_bits_per_sample,
	output logic            subclass1_mode,
	input  wire logic       link_clock,
	input  wire logic       sysref,
	output logic [7:0]      lmfc_phase,
	output logic            lmfc_tick
);
	// pin synchronisers, third stage only for edge finding
	logic       sclk_s1, sclk_s2, sclk_s3;
	logic       csn_s1, csn_s2;
	logic       sdi_s1, sdi_s2;
	// serial port engine
	slpr_pkg::slpr_spi_state_t st_reg;
	logic [3:0]  cnt_reg;
	logic [15:0] instr_reg;
	logic [12:0] addr_reg;
	logic [7:0]  rx_reg;
	logic [7:0]  tx_reg;
	logic        oe_reg;
	// stored fields
	logic        scr_en_reg;
	logic [4:0]  lane_reg;
	logic [7:0]  k_reg;
	logic [7:0]  m_reg;
	logic [1:0]  cs_reg;
	logic [1:0]  sub_reg;
	logic        srsv_reg;
	logic [7:0]  scr1_reg;
	logic [7:0]  scr2_reg;
	logic        drv_pd_reg;
	logic [4:0]  off_reg;
	logic [7:0]  emph_reg;
	logic        emph_en_reg;
	logic [1:0]  cbits_reg;
	logic        sub1_reg;
	logic        cfg_tgl_reg; // flips on each K or offset write
	// octets per frame from converters and lanes, both minus-one coded
	function automatic logic [7:0] f_calc(input logic [7:0] m,
		input logic [4:0] l);
		logic [9:0] num, den;
		num = ({2'h0, m} + 10'h001) << 1;
		den = {5'h00, l} + 10'h001;
		f_calc = num[7:0] / den[7:0];
	endfunction
	// eight-bit wrapping sum
	function automatic logic [7:0] add8(input logic [7:0] a,
		input logic [7:0] b);
		add8 = a + b;
	endfunction
	// port edges and decoded instruction
	wire        sclk_rise = sclk_s2 & ~sclk_s3;
	wire        active    = ~csn_s2;
	wire        take      = active & sclk_rise;
	wire [15:0] full_ins  = {instr_reg[14:0], sdi_s2};
	wire        ins_read  = full_ins[`SLPR_RW_BIT];
	wire [12:0] ins_addr  = full_ins[`SLPR_ADDR_MSB:0];
	wire [7:0]  wdata     = {rx_reg[6:0], sdi_s2};
	wire        wr_stb    = take && st_reg == slpr_pkg::ST_WDATA &&
		cnt_reg == `SLPR_DATA_LAST;
	// derived parameters
	wire [7:0]  f_val     = f_calc(m_reg, lane_reg);
	wire [7:0]  f_m1      = f_val - 8'h01;
	wire [7:0]  cksum = add8(add8(add8(add8({3'h0, lane_reg},
		{7'h00, scr_en_reg}), add8(f_m1, k_reg)),
		add8(add8(m_reg, {6'h00, cs_reg}), {4'h0, `SLPR_N_VAL})),
		add8(add8({6'h00, sub_reg}, {4'h0, `SLPR_NP_VAL}),
		add8({3'h0, `SLPR_S_VAL},
		add8({7'h00, `SLPR_HD_VAL}, {3'h0, `SLPR_CF_VAL}))));
	// read selection; fixed fields come from constants, never storage
	logic [7:0] rd_data;
	always_comb begin
		if (ins_addr == `SLPR_A_SCR_LANE) begin
			rd_data = {scr_en_reg, 2'h0, lane_reg};
		end else if (ins_addr == `SLPR_A_F) begin
			rd_data = f_val;
		end else if (ins_addr == `SLPR_A_K) begin
			rd_data = k_reg;
		end else if (ins_addr == `SLPR_A_M) begin
			rd_data = m_reg;
		end else if (ins_addr == `SLPR_A_NCS) begin
			rd_data = {cs_reg, 2'h0, `SLPR_N_VAL};
		end else if (ins_addr == `SLPR_A_SUBNP) begin
			rd_data = {1'h0, sub_reg, 1'h0, `SLPR_NP_VAL};
		end else if (ins_addr == `SLPR_A_S) begin
			rd_data = {2'h0, srsv_reg, `SLPR_S_VAL};
		end else if (ins_addr == `SLPR_A_HDCF) begin
			rd_data = {`SLPR_HD_VAL, 2'h0, `SLPR_CF_VAL};
		end else if (ins_addr == `SLPR_A_SCR1) begin
			rd_data = scr1_reg;
		end else if (ins_addr == `SLPR_A_SCR2) begin
			rd_data = scr2_reg;
		end else if (ins_addr == `SLPR_A_CKSUM) begin
			rd_data = cksum;
		end else if (ins_addr == `SLPR_A_DRV) begin
			rd_data = {6'h00, drv_pd_reg, 1'h0};
		end else if (ins_addr == `SLPR_A_LMFC) begin
			rd_data = {3'h0, off_reg};
		end else if (ins_addr == `SLPR_A_EMPH) begin
			rd_data = emph_reg;
		end else begin
			// unmapped reads as zero
			rd_data = 8'h00;
		end
	end
	// two flops on every pin before use
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			csn_s1  <= 1'b1;
			csn_s2  <= 1'b1;
			sdi_s1  <= 1'b0;
			sdi_s2  <= 1'b0;
		end else begin
			sclk_s1 <= spi_sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			csn_s1  <= spi_cs_n;
			csn_s2  <= csn_s1;
			sdi_s1  <= sdio_in;
			sdi_s2  <= sdi_s1;
		end
	end
	// transfer sequencer: 16 instruction bits then one data byte
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_reg  <= slpr_pkg::ST_INSTR;
			cnt_reg <= 4'h0;
		end else if (!active) begin
			// deselect aborts any partial transfer
			st_reg  <= slpr_pkg::ST_INSTR;
			cnt_reg <= 4'h0;
		end else if (sclk_rise) begin
			cnt_reg <= cnt_reg + 4'h1;
			case (st_reg)
				slpr_pkg::ST_INSTR: begin
					if (cnt_reg == `SLPR_INSTR_LAST) begin
						st_reg <= ins_read ? slpr_pkg::ST_RDATA :
							slpr_pkg::ST_WDATA;
					end
				end
				slpr_pkg::ST_WDATA, slpr_pkg::ST_RDATA: begin
					if (cnt_reg == `SLPR_DATA_LAST) begin
						st_reg <= slpr_pkg::ST_DONE;
					end
				end
				default: begin
					// extra clocks ignored until deselect
					cnt_reg <= cnt_reg;
				end
			endcase
		end
	end
	// shift registers for instruction and write data
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			instr_reg <= 16'h0000;
			rx_reg    <= 8'h00;
			addr_reg  <= 13'h0000;
		end else if (take) begin
			instr_reg <= full_ins;
			rx_reg    <= wdata;
			if (st_reg == slpr_pkg::ST_INSTR &&
				cnt_reg == `SLPR_INSTR_LAST) begin
				addr_reg <= ins_addr;
			end
		end
	end
	// read path: launch on rising edge so host samples a settled bit
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_reg <= 8'h00;
			oe_reg <= 1'b0;
		end else if (!active) begin
			oe_reg <= 1'b0;
		end else if (take) begin
			if (st_reg == slpr_pkg::ST_INSTR &&
				cnt_reg == `SLPR_INSTR_LAST && ins_read) begin
				tx_reg <= rd_data;
				oe_reg <= 1'b1;
			end else if (st_reg == slpr_pkg::ST_RDATA) begin
				tx_reg <= {tx_reg[6:0], 1'b0};
				oe_reg <= cnt_reg != `SLPR_DATA_LAST;
			end
		end
	end
	assign sdio_out = tx_reg[7];
	assign sdio_oe  = oe_reg;
	// writable fields; fixed fields have no storage at all
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scr_en_reg <= 1'b0;
			lane_reg   <= 5'h00;
			k_reg      <= `SLPR_RST_K;
			m_reg      <= 8'h00;
			cs_reg     <= 2'h0;
			sub_reg    <= 2'h0;
			srsv_reg   <= `SLPR_RST_SRSV;
			scr1_reg   <= 8'h00;
			scr2_reg   <= 8'h00;
			drv_pd_reg <= 1'b0;
			off_reg    <= 5'h00;
			emph_reg   <= `SLPR_EMPH_OFF;
			cfg_tgl_reg <= 1'b0;
		end else if (wr_stb) begin
			if (addr_reg == `SLPR_A_SCR_LANE) begin
				scr_en_reg <= wdata[`SLPR_SCR_BIT];
				lane_reg   <= wdata[`SLPR_LANE_MSB:0];
			end else if (addr_reg == `SLPR_A_K) begin
				k_reg <= wdata;
				cfg_tgl_reg <= ~cfg_tgl_reg;
			end else if (addr_reg == `SLPR_A_M) begin
				m_reg <= wdata;
			end else if (addr_reg == `SLPR_A_NCS) begin
				cs_reg <= wdata[`SLPR_CS_MSB:`SLPR_CS_LSB];
			end else if (addr_reg == `SLPR_A_SUBNP) begin
				sub_reg <= wdata[`SLPR_SUB_MSB:`SLPR_SUB_LSB];
			end else if (addr_reg == `SLPR_A_S) begin
				srsv_reg <= wdata[`SLPR_SRSV_BIT];
			end else if (addr_reg == `SLPR_A_SCR1) begin
				scr1_reg <= wdata;
			end else if (addr_reg == `SLPR_A_SCR2) begin
				scr2_reg <= wdata;
			end else if (addr_reg == `SLPR_A_DRV) begin
				drv_pd_reg <= wdata[`SLPR_DRV_PD_BIT];
			end else if (addr_reg == `SLPR_A_LMFC) begin
				off_reg <= wdata[`SLPR_OFF_MSB:0];
				cfg_tgl_reg <= ~cfg_tgl_reg;
			end else if (addr_reg == `SLPR_A_EMPH) begin
				emph_reg <= wdata;
			end
		end
	end
	// decoded controls, registered so outputs come from flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			emph_en_reg <= 1'b0;
			cbits_reg   <= 2'h0;
			sub1_reg    <= 1'b0;
		end else begin
			// other emphasis codes leave it off
			emph_en_reg <= emph_reg == `SLPR_EMPH_ON;
			// code 11 is undefined; held at two bits
			cbits_reg   <= (cs_reg == 2'h3) ? 2'h2 : cs_reg;
			sub1_reg    <= sub_reg == `SLPR_SUB1_CODE;
		end
	end
	assign scramble_en          = scr_en_reg;
	assign driver_power_down    = drv_pd_reg;
	assign preemphasis_en       = emph_en_reg;
	assign ctrl_bits_per_sample = cbits_reg;
	assign subclass1_mode       = sub1_reg;
	// link domain: reset release and toggle-synchronised config crossing, no acknowledge
	logic       lrst_s1, lrst_s2, tgl_s1, tgl_s2, tgl_s3;
	logic [7:0] k_s2;   // taken only once the write toggle has settled
	logic [4:0] off_s2; // likewise, so no field crosses mid-change
	logic       sys_s1, sys_s2, sys_s3;
	logic [7:0] phase_reg;
	logic       tick_reg;
	// link reset asserts at once, releases on the link clock
	always_ff @(posedge link_clock or posedge rst) begin
		if (rst) begin
			lrst_s1 <= 1'b1;
			lrst_s2 <= 1'b1;
		end else begin
			lrst_s1 <= 1'b0;
			lrst_s2 <= lrst_s1;
		end
	end
	// config captured on a settled write toggle; sysref synchronised
	always_ff @(posedge link_clock or posedge lrst_s2) begin
		if (lrst_s2) begin
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
			k_s2   <= `SLPR_RST_K;
			off_s2 <= 5'h00;
			sys_s1 <= 1'b0;
			sys_s2 <= 1'b0;
			sys_s3 <= 1'b0;
		end else begin
			tgl_s1 <= cfg_tgl_reg;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
			// fields stood still since the toggle flipped
			if (tgl_s2 != tgl_s3) begin
				k_s2   <= k_reg;
				off_s2 <= off_reg;
			end
			sys_s1 <= sysref;
			sys_s2 <= sys_s1;
			sys_s3 <= sys_s2;
		end
	end
	// multiframe phase counter counts frames 0..K-1
	wire sys_edge  = sys_s2 & ~sys_s3;
	wire [7:0] k_m1 = (k_s2 == 8'h00) ? 8'h00 : k_s2 - 8'h01;
	wire [7:0] phase_next = sys_edge ? {3'h0, off_s2} :
		(phase_reg >= k_m1) ? 8'h00 : phase_reg + 8'h01;
	always_ff @(posedge link_clock or posedge lrst_s2) begin
		if (lrst_s2) begin
			phase_reg <= 8'h00;
			tick_reg  <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			tick_reg  <= phase_next == 8'h00;
		end
	end
	assign lmfc_phase = phase_reg;
	assign lmfc_tick  = tick_reg;
	// checks in the register domain, the last one in the link domain
	wire wr_at_scr  = wr_stb && addr_reg == `SLPR_A_SCR_LANE;
	wire wr_at_emph = wr_stb && addr_reg == `SLPR_A_EMPH;
	sequence s_emph_on;
		wr_at_emph && wdata == `SLPR_EMPH_ON;
	endsequence
	sequence s_emph_off;
		wr_at_emph && wdata == `SLPR_EMPH_OFF;
	endsequence
	chk_scr_follow: assert property (@(posedge clock) disable iff (rst)
		wr_at_scr |=> scramble_en == $past(wdata[7]))
		else $error("scrambler enable not taken");
	chk_f_default: assert property (@(posedge clock) disable iff (rst)
		(m_reg == 8'h00 && lane_reg == 5'h00) |-> f_val == 8'h02)
		else $error("octets per frame not two");
	chk_n_fixed: assert property (@(posedge clock) disable iff (rst)
		ins_addr == `SLPR_A_NCS |-> rd_data[3:0] == 4'hD)
		else $error("resolution field wrong");
	chk_np_fixed: assert property (@(posedge clock) disable iff (rst)
		ins_addr == `SLPR_A_SUBNP |-> rd_data[3:0] == 4'hF)
		else $error("sample bits field wrong");
	chk_s_fixed: assert property (@(posedge clock) disable iff (rst)
		ins_addr == `SLPR_A_S |-> rd_data[4:0] == 5'h00)
		else $error("samples field not zero");
	chk_hdcf_zero: assert property (@(posedge clock) disable iff (rst)
		ins_addr == `SLPR_A_HDCF |-> rd_data == 8'h00)
		else $error("density or control words not zero");
	chk_scratch_rb: assert property (@(posedge clock) disable iff (rst)
		(wr_stb && addr_reg == `SLPR_A_SCR1) |=> scr1_reg == $past(wdata))
		else $error("scratch register lost write");
	chk_cksum_dflt: assert property (@(posedge clock) disable iff (rst)
		(lane_reg == 5'h00 && !scr_en_reg && k_reg == 8'h20 &&
		m_reg == 8'h00 && cs_reg == 2'h0 && sub_reg == 2'h0)
		|-> cksum == 8'h3D)
		else $error("checksum wrong for defaults");
	chk_drv_pd: assert property (@(posedge clock) disable iff (rst)
		(wr_stb && addr_reg == `SLPR_A_DRV) |=>
		driver_power_down == $past(wdata[1]))
		else $error("driver power down not taken");
	chk_emph_on: assert property (@(posedge clock) disable iff (rst)
		s_emph_on |=> ##1 preemphasis_en)
		else $error("preemphasis not enabled");
	chk_emph_off: assert property (@(posedge clock) disable iff (rst)
		s_emph_off |=> ##1 !preemphasis_en)
		else $error("preemphasis not disabled");
	chk_cs_decode: assert property (@(posedge clock) disable iff (rst)
		cs_reg == 2'h1 |=> ctrl_bits_per_sample == 2'h1)
		else $error("control bit count wrong");
	chk_sub_mode: assert property (@(posedge clock) disable iff (rst)
		sub_reg == 2'h0 |=> !subclass1_mode)
		else $error("subclass mode wrong");
	chk_lmfc_load: assert property (@(posedge link_clock)
		disable iff (lrst_s2)
		sys_edge |=> lmfc_phase == {3'h0, $past(off_s2)})
		else $error("phase offset not loaded on sysref");
endmodule

// *** dv/slpr_spi_host.sv ***
// behavioural three-wire serial port host for the link parameter bank
module slpr_spi_host (
	input  wire logic clock,
	input  wire logic sdio_out,
	input  wire logic sdio_oe,
	output logic      spi_sclk,
	output logic      spi_cs_n,
	output logic      sdio_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic host_oe;  // host owns the data line
	logic host_bit; // level the host drives
	logic last_bit; // last settled wire level
	// wire level; an idle line flips each cycle so no stale bit passes
	assign sdio_in = sdio_oe ? sdio_out : (host_oe ? host_bit : ~last_bit);
	always @(posedge clock) last_bit <= sdio_in;
	// clocks stand still and select is high outside frames
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		host_oe  = 1'b0;
		host_bit = 1'b0;
		last_bit = 1'b0;
	end
	// half a serial clock period, four register clocks
	task automatic half;
		repeat (4) @(posedge clock);
		#2;
	endtask
	// one frame: 16 instruction bits then 8 data bits, msb first
	task automatic xfer(input logic [15:0] ins, input logic [7:0] wd,
		output logic [7:0] rdat);
		logic [23:0] sh;
		sh = {ins, wd};
		rdat = 8'h00;
		spi_cs_n = 1'b0;
		for (int i = 0; i < 24; i++) begin
			// host lets go of the line for read data
			host_oe = (i < 16) || !ins[15];
			host_bit = sh[23 - i];
			half;
			// bit launched after the previous rise is taken here
			if (ins[15] && i >= 16) rdat[23 - i] = sdio_in;
			spi_sclk = 1'b1;
			half;
			spi_sclk = 1'b0;
		end
		host_oe = 1'b0;
		half;
		spi_cs_n = 1'b1;
		half; // idle gap between frames, above three clocks
	endtask
endmodule

// *** dv/slpr_regs_top_tb_top.sv ***
// self-checking bench for the link parameter register bank
module slpr_regs_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clock, rst, link_clock, sysref;
	logic       spi_sclk, spi_cs_n, sdio_in, sdio_out, sdio_oe;
	logic       scramble_en, driver_power_down, preemphasis_en;
	logic [1:0] ctrl_bits_per_sample;
	logic       subclass1_mode, lmfc_tick;
	logic [7:0] lmfc_phase, rd, prev, jval;
	int         n_errors, checks_done, jumps, ticks;
	// reset map: addresses and values, unmapped 0x78 among them
	logic [12:0] ra [14] = '{13'h006E, 13'h006F, 13'h0070, 13'h0071,
		13'h0072, 13'h0073, 13'h0074, 13'h0075, 13'h0076, 13'h0077,
		13'h0078, 13'h0080, 13'h008B, 13'h00A8};
	logic [7:0] rv [14] = '{8'h00, 8'h02, 8'h20, 8'h00, 8'h0D, 8'h0F,
		8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
	slpr_regs_top slpr_regs_top_i (
		.clock(clock), .rst(rst), .spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
		.sdio_oe(sdio_oe), .scramble_en(scramble_en),
		.driver_power_down(driver_power_down),
		.preemphasis_en(preemphasis_en),
		.ctrl_bits_per_sample(ctrl_bits_per_sample),
		.subclass1_mode(subclass1_mode), .link_clock(link_clock),
		.sysref(sysref), .lmfc_phase(lmfc_phase), .lmfc_tick(lmfc_tick));
	slpr_spi_host slpr_spi_host_i (
		.clock(clock), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .sdio_in(sdio_in));
	// register clock, 20 ns
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// link clock, 80 ns, phase unrelated to the register clock
	initial begin
		link_clock = 1'b0;
		#7;
		forever #40 link_clock = ~link_clock;
	end
	// byte compare, the one result kind
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	// write: bit15 low
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		slpr_spi_host_i.xfer({3'b000, a}, d, rd);
	endtask
	// read and compare: bit15 high
	task automatic rdc(input logic [12:0] a, input logic [7:0] e);
		slpr_spi_host_i.xfer({3'b100, a}, 8'h00, rd);
		chk8(rd, e);
	endtask
	task automatic lk(input int n);
		repeat (n) @(posedge link_clock);
		#2;
	endtask
	// checksum with lane, scrambler and converters at zero, F less one
	function automatic logic [7:0] cks(input logic [7:0] k,
		input logic [1:0] cs, input logic [1:0] sub);
		return 8'h01 + k + {6'h00, cs} + {6'h00, sub} + 8'h0D + 8'h0F;
	endfunction
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// hang guard
	initial begin
		#1ms;
		n_errors++;
		print_verdict;
	end
	// main sequence
	initial begin
		rst = 1'b1;
		sysref = 1'b0;
		n_errors = 0;
		checks_done = 0;
		repeat (12) @(posedge clock);
		#2 rst = 1'b0;
		repeat (4) @(posedge clock);
		#2;
		chk1(scramble_en, 1'b0);
		chk1(preemphasis_en, 1'b0);
		for (int i = 0; i < 14; i++) rdc(ra[i], rv[i]);
		rdc(13'h0079, cks(8'h20, 2'h0, 2'h0));
		$display("test reset_map done");
		wr(13'h006E, 8'h80);
		chk1(scramble_en, 1'b1);
		rdc(13'h006E, 8'h80);
		rdc(13'h006F, 8'h02);
		wr(13'h006E, 8'h00);
		chk1(scramble_en, 1'b0);
		wr(13'h006F, 8'h55);
		rdc(13'h006F, 8'h02);
		wr(13'h0075, 8'hFF);
		rdc(13'h0075, 8'h00);
		wr(13'h0074, 8'h3F);
		rdc(13'h0074, 8'h20);
		wr(13'h0078, 8'hA5);
		rdc(13'h0078, 8'h00);
		$display("test fixed_fields done");
		// every control bit code, 11 held at two, fixed resolution kept
		for (int c = 0; c < 4; c++) begin
			wr(13'h0072, {c[1:0], 6'h0F});
			chk8({6'h00, ctrl_bits_per_sample},
				(c == 3) ? 8'h02 : {6'h00, c[1:0]});
			rdc(13'h0072, {c[1:0], 6'h0D});
		end
		// both subclass codes, sample bits written as zero
		for (int s = 0; s < 2; s++) begin
			wr(13'h0073, {1'b0, s[1:0], 5'h00});
			chk1(subclass1_mode, s == 1);
			rdc(13'h0073, {1'b0, s[1:0], 5'h0F});
		end
		$display("test codes done");
		wr(13'h0076, 8'hA5);
		wr(13'h0077, 8'h5A);
		rdc(13'h0076, 8'hA5);
		rdc(13'h0077, 8'h5A);
		chk1(sdio_oe, 1'b0);
		wr(13'h0080, 8'h02);
		chk1(driver_power_down, 1'b1);
		rdc(13'h0080, 8'h02);
		wr(13'h0080, 8'h00);
		chk1(driver_power_down, 1'b0);
		wr(13'h00A8, 8'h14);
		chk1(preemphasis_en, 1'b1);
		rdc(13'h00A8, 8'h14);
		wr(13'h00A8, 8'h04);
		chk1(preemphasis_en, 1'b0);
		$display("test outputs done");
		// multiframe of 16 frames, a multiple of four, drivers held down
		wr(13'h0080, 8'h02);
		wr(13'h0070, 8'h10);
		wr(13'h008B, 8'h0B);
		rdc(13'h0079, cks(8'h10, 2'h3, 2'h1));
		wr(13'h0080, 8'h00);
		lk(300); // settle time; a count past the new length wraps to zero at once
		ticks = 0;
		for (int i = 0; i < 32; i++) begin
			prev = lmfc_phase;
			lk(1);
			chk8(lmfc_phase, (prev + 8'h01) & 8'h0F);
			chk1(lmfc_tick, lmfc_phase === 8'h00);
			if (lmfc_tick === 1'b1) ticks++;
		end
		chk8(ticks[7:0], 8'h02);
		// align to phase zero so the load shows as a jump
		for (int i = 0; i < 20 && lmfc_phase !== 8'h00; i++) lk(1);
		if (lmfc_phase !== 8'h00) n_errors++;
		sysref = 1'b1;
		jumps = 0;
		jval = 8'h00;
		for (int i = 0; i < 10; i++) begin
			prev = lmfc_phase;
			lk(1);
			if (lmfc_phase !== ((prev + 8'h01) & 8'h0F)) begin
				jumps++;
				jval = lmfc_phase;
			end
		end
		sysref = 1'b0;
		chk8(jumps[7:0], 8'h01);
		chk8(jval, 8'h0B);
		$display("test multiframe done");
		print_verdict;
	end
endmodule
